// file: hdl/csd_pkg.sv
// constants, field positions and operation codes of the stack, status and datapath block
// How it works
// - six-entry return stack holds only program counter values, hidden from software
// - call or interrupt acknowledge pushes the program counter and advances level unless the stack is full
// - return or interrupt return reloads the program counter from newest entry
// - reset empties the stack, level pointer at top
// - current-page table read takes upper four address bits from program counter
// - both table reads take low eight address bits from table pointer
// - full stack holds interrupt acknowledge until a return frees a level
// - call on a full stack overwrites the oldest entry
// - data memory holds function registers plus 192 general bytes
// - any data bit can be set or cleared, dedicated bits excepted
// - locations 00H and 02H reach memory through pointer zero or one
// - pointer aimed at an indirect location reads 00H, writes nothing
// - accumulator sits at 05H, takes immediates, carries memory moves
// - ALU does 8-bit arithmetic, logic, rotates, inc, dec, skips, flags
// - status writes never touch power-down or timeout flags; bits 6, 7 read zero
// - carry set on add carry or subtract no-borrow, rotates through it
// - half carry set on low nibble carry or no nibble borrow
// - zero flag set when result is zero
// - overflow set when carry into and out of top bit differ
// - power-down flag cleared by reset or watchdog clear, set by halt
// - timeout flag cleared by reset, watchdog clear or halt, set by timeout
// - status register is never saved automatically on call or interrupt
package csd_pkg;
  localparam int PC_W        = 12;
  localparam int DATA_W      = 8;
  localparam int STACK_DEPTH = 6;
  localparam int GP_BYTES    = 192;
  localparam logic [7:0] ADDR_IND0    = 8'h00;
  localparam logic [7:0] ADDR_PTR0    = 8'h01;
  localparam logic [7:0] ADDR_IND1    = 8'h02;
  localparam logic [7:0] ADDR_PTR1    = 8'h03;
  localparam logic [7:0] ADDR_ACC     = 8'h05;
  localparam logic [7:0] ADDR_TBL_PTR = 8'h07;
  localparam logic [7:0] ADDR_STATUS  = 8'h0A;
  localparam logic [7:0] ADDR_GP_BASE = 8'h40;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] IND_SELF_RD  = 8'h00;
  localparam logic [3:0] LAST_PAGE    = 4'hF;
  localparam int ST_CARRY    = 0;
  localparam int ST_HALF     = 1;
  localparam int ST_ZERO     = 2;
  localparam int ST_OVERFLOW = 3;
  localparam int ST_PWRDN    = 4;
  localparam int ST_WDOG     = 5;
  typedef enum logic [4:0] {
    OP_PASS, OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW, OP_DEC_ADJUST,
    OP_AND, OP_OR, OP_XOR, OP_COMPLEMENT, OP_ROT_LEFT, OP_ROT_RIGHT,
    OP_ROT_LEFT_C, OP_ROT_RIGHT_C, OP_INC, OP_DEC, OP_SKIP_ZERO,
    OP_SKIP_NONZERO, OP_INC_SKIP_ZERO, OP_DEC_SKIP_ZERO
  } csd_op_type;
endpackage

// file: hdl/csd_stack.sv
// circular return-address stack with saturating level count
`timescale 1ns/10ps
`default_nettype none
module csd_stack import csd_pkg::*; #(
  parameter int DEPTH = STACK_DEPTH,
  parameter int AW    = PC_W
) (
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  input  wire logic                         push,
  input  wire logic                         pop,
  input  wire logic [AW-1:0]                push_data,
  output logic      [AW-1:0]                top_data,
  output logic                              full,
  output logic      [$clog2(DEPTH+1)-1:0]   level
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  logic [AW-1:0] entry_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [LW-1:0] level_q;
  wire  [PW-1:0] next_ptr = (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
  wire  [PW-1:0] prev_ptr = (wr_ptr_q == '0) ? PW'(DEPTH-1) : wr_ptr_q - 1'b1;
  assign top_data = entry_q[prev_ptr];
  assign full     = (level_q == LW'(DEPTH));
  assign level    = level_q;
  always_ff @(posedge sys_clk) begin
    if (push) begin
      entry_q[wr_ptr_q] <= push_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      level_q  <= '0;
    end else if (push) begin
      wr_ptr_q <= next_ptr;
      if (!full) begin
        level_q <= level_q + 1'b1;
      end
    end else if (pop) begin
      wr_ptr_q <= prev_ptr;
      if (level_q != '0) begin
        level_q <= level_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/csd_alu.sv
// combinational 8-bit arithmetic and logic unit with flag outputs
`timescale 1ns/10ps
`default_nettype none
module csd_alu import csd_pkg::*; (
  input  wire csd_op_type       op,
  input  wire logic [7:0]       acc,
  input  wire logic [7:0]       opnd,
  input  wire logic             c_in,
  input  wire logic             hc_in,
  output logic      [7:0]       result,
  output logic                  c_out,
  output logic                  hc_out,
  output logic                  ov_out,
  output logic                  z_out,
  output logic                  upd_carry,
  output logic                  upd_arith,
  output logic                  upd_zero,
  output logic                  writes,
  output logic                  skip
);
  wire       is_sub   = (op == OP_SUB) || (op == OP_SUB_BORROW);
  wire       use_c    = (op == OP_ADD_CARRY) || (op == OP_SUB_BORROW);
  wire [7:0] addend   = is_sub ? ~opnd : opnd;
  wire       cin      = use_c ? c_in : is_sub;
  wire [4:0] low_sum  = {1'b0, acc[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
  wire [7:0] low7_sum = {1'b0, acc[6:0]} + {1'b0, addend[6:0]} + {7'h00, cin};
  wire [8:0] sum      = {1'b0, acc} + {1'b0, addend} + {8'h00, cin};
  wire       adj_lo   = (acc[3:0] > 4'h9) || hc_in;
  wire [8:0] daa_lo   = {1'b0, acc} + (adj_lo ? 9'h006 : 9'h000);
  wire       adj_hi   = daa_lo[8] || (daa_lo[7:4] > 4'h9) || c_in;
  wire [8:0] daa_hi   = daa_lo + (adj_hi ? 9'h060 : 9'h000);
  wire [7:0] inc_val  = opnd + 8'h01;
  wire [7:0] dec_val  = opnd - 8'h01;
  assign z_out  = (result == 8'h00);
  assign hc_out = low_sum[4];
  // carry in versus out of top bit
  assign ov_out = low7_sum[7] ^ sum[8];
  always_comb begin
    result    = opnd;
    c_out     = c_in;
    upd_carry = 1'b0;
    upd_arith = 1'b0;
    upd_zero  = 1'b0;
    writes    = 1'b1;
    skip      = 1'b0;
    case (op)
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW: begin
        result    = sum[7:0];
        c_out     = sum[8];
        upd_carry = 1'b1;
        upd_arith = 1'b1;
        upd_zero  = 1'b1;
      end
      OP_DEC_ADJUST: begin
        result    = daa_hi[7:0];
        c_out     = adj_hi || daa_hi[8];
        upd_carry = 1'b1;
      end
      OP_AND: begin result = acc & opnd; upd_zero = 1'b1; end
      OP_OR: begin result = acc | opnd; upd_zero = 1'b1; end
      OP_XOR: begin result = acc ^ opnd; upd_zero = 1'b1; end
      OP_COMPLEMENT: begin result = ~opnd; upd_zero = 1'b1; end
      OP_ROT_LEFT: result = {opnd[6:0], opnd[7]};
      OP_ROT_RIGHT: result = {opnd[0], opnd[7:1]};
      OP_ROT_LEFT_C: begin
        result    = {opnd[6:0], c_in};
        c_out     = opnd[7];
        upd_carry = 1'b1;
      end
      OP_ROT_RIGHT_C: begin
        result    = {c_in, opnd[7:1]};
        c_out     = opnd[0];
        upd_carry = 1'b1;
      end
      OP_INC: begin result = inc_val; upd_zero = 1'b1; end
      OP_DEC: begin result = dec_val; upd_zero = 1'b1; end
      OP_SKIP_ZERO: begin writes = 1'b0; skip = (opnd == 8'h00); end
      OP_SKIP_NONZERO: begin writes = 1'b0; skip = (opnd != 8'h00); end
      OP_INC_SKIP_ZERO: begin result = inc_val; skip = (inc_val == 8'h00); end
      OP_DEC_SKIP_ZERO: begin result = dec_val; skip = (dec_val == 8'h00); end
      default: result = opnd;
    endcase
  end
endmodule
`default_nettype wire

// file: hdl/csd_datapath.sv
// core datapath: return stack, table address, data memory, accumulator, ALU and status
`timescale 1ns/10ps
`default_nettype none
module csd_datapath import csd_pkg::*; #(
  parameter int GP_SIZE = GP_BYTES
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [PC_W-1:0]  pc_value,
  input  wire logic             call_exec,
  input  wire logic             return_exec,
  input  wire logic             return_int_exec,
  input  wire logic             int_request,
  output logic                  int_ack,
  output logic      [PC_W-1:0]  pc_restore,
  output logic                  pc_restore_valid,
  input  wire logic             table_cur_exec,
  input  wire logic             table_last_exec,
  output logic      [PC_W-1:0]  table_addr,
  output logic                  table_addr_valid,
  input  wire logic [7:0]       mem_addr,
  input  wire logic             mem_read,
  input  wire logic             mem_write,
  input  wire logic [7:0]       mem_wdata,
  output logic      [7:0]       mem_rdata,
  input  wire logic             bit_set_exec,
  input  wire logic             bit_clear_exec,
  input  wire logic [2:0]       bit_index,
  input  wire logic             alu_exec,
  input  wire csd_op_type       alu_op,
  input  wire logic             alu_use_imm,
  input  wire logic [7:0]       alu_imm,
  input  wire logic             alu_to_mem,
  output logic                  skip_next,
  input  wire logic             halt_exec,
  input  wire logic             watchdog_clear_exec,
  input  wire logic             watchdog_timeout,
  output logic      [7:0]       accumulator,
  output logic      [5:0]       status_flags,
  output logic      [2:0]       stack_level
);

  // ---- storage
  logic [7:0]      acc_q;
  logic [7:0]      ptr0_q;
  logic [7:0]      ptr1_q;
  logic [7:0]      tbl_ptr_q;
  logic [5:0]      flag_q;
  logic [7:0]      gp_q [GP_SIZE];
  logic [7:0]      rdata_q;
  logic            int_ack_q;
  logic [PC_W-1:0] pc_restore_q;
  logic            pc_restore_valid_q;
  logic [PC_W-1:0] table_addr_q;
  logic            table_addr_valid_q;
  logic            skip_q;

  // ---- location decoding, used for read select and pointer checks
  function automatic logic is_indirect(input logic [7:0] a);
    is_indirect = (a == ADDR_IND0) || (a == ADDR_IND1);
  endfunction

  function automatic logic is_gp(input logic [7:0] a);
    is_gp = (a >= ADDR_GP_BASE);
  endfunction

  // unmapped locations read as zero
  function automatic logic [7:0] read_loc(input logic [7:0] a);
    logic [7:0] idx;
    idx = a - ADDR_GP_BASE;
    read_loc = 8'h00;
    if (is_gp(a)) begin
      read_loc = gp_q[idx];
    end else begin
      case (a)
        ADDR_PTR0:    read_loc = ptr0_q;
        ADDR_PTR1:    read_loc = ptr1_q;
        ADDR_ACC:     read_loc = acc_q;
        ADDR_TBL_PTR: read_loc = tbl_ptr_q;
        ADDR_STATUS:  read_loc = {2'b00, flag_q};
        default:      read_loc = 8'h00;
      endcase
    end
  endfunction

  // ---- indirect addressing
  // pointer substitution
  wire       via_ptr0 = (mem_addr == ADDR_IND0);
  wire       via_ptr1 = (mem_addr == ADDR_IND1);
  wire [7:0] eff_addr = via_ptr0 ? ptr0_q : (via_ptr1 ? ptr1_q : mem_addr);
  wire       ind_self = (via_ptr0 || via_ptr1) && is_indirect(eff_addr);
  logic [7:0] loc_data;
  // a process, so stored bytes read inside the function wake it
  always_comb begin
    loc_data = ind_self ? IND_SELF_RD : read_loc(eff_addr);
  end

  // ---- ALU
  wire [7:0] alu_opnd = alu_use_imm ? alu_imm : loc_data;
  wire [7:0] alu_result;
  wire       alu_c;
  wire       alu_hc;
  wire       alu_ov;
  wire       alu_z;
  wire       upd_carry;
  wire       upd_arith;
  wire       upd_zero;
  wire       alu_writes;
  wire       alu_skip;

  csd_alu u_alu (
    .op        (alu_op),
    .acc       (acc_q),
    .opnd      (alu_opnd),
    .c_in      (flag_q[ST_CARRY]),
    .hc_in     (flag_q[ST_HALF]),
    .result    (alu_result),
    .c_out     (alu_c),
    .hc_out    (alu_hc),
    .ov_out    (alu_ov),
    .z_out     (alu_z),
    .upd_carry (upd_carry),
    .upd_arith (upd_arith),
    .upd_zero  (upd_zero),
    .writes    (alu_writes),
    .skip      (alu_skip)
  );

  // ---- single write port into data memory
  // read-modify-write of one bit
  wire       bit_exec  = bit_set_exec || bit_clear_exec;
  wire [7:0] bit_mask  = 8'h01 << bit_index;
  wire [7:0] bit_byte  = bit_set_exec ? (loc_data | bit_mask) : (loc_data & ~bit_mask);
  wire       alu_mem_w = alu_exec && alu_to_mem && alu_writes;
  wire       alu_acc_w = alu_exec && !alu_to_mem && alu_writes;
  wire       wr_en     = (mem_write || bit_exec || alu_mem_w) && !ind_self;
  wire [7:0] wr_data   = mem_write ? mem_wdata : (bit_exec ? bit_byte : alu_result);
  wire       wr_acc    = wr_en && (eff_addr == ADDR_ACC);
  wire       wr_ptr0   = wr_en && (eff_addr == ADDR_PTR0);
  wire       wr_ptr1   = wr_en && (eff_addr == ADDR_PTR1);
  wire       wr_tbl    = wr_en && (eff_addr == ADDR_TBL_PTR);
  wire       wr_status = wr_en && (eff_addr == ADDR_STATUS);

  genvar gi;
  generate
    for (gi = 0; gi < GP_SIZE; gi++) begin : g_gp
      localparam logic [7:0] LOC = 8'(int'(ADDR_GP_BASE) + gi);
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          gp_q[gi] <= RST_BYTE;
        end else if (wr_en && (eff_addr == LOC)) begin
          gp_q[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // accumulator is both ALU target and location 05H
  wire [7:0] acc_d = alu_acc_w ? alu_result : (wr_acc ? wr_data : acc_q);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc_q     <= RST_BYTE;
      ptr0_q    <= RST_BYTE;
      ptr1_q    <= RST_BYTE;
      tbl_ptr_q <= RST_BYTE;
    end else begin
      acc_q <= acc_d;
      if (wr_ptr0) ptr0_q <= wr_data;
      if (wr_ptr1) ptr1_q <= wr_data;
      if (wr_tbl) tbl_ptr_q <= wr_data;
    end
  end

  // ---- status flags
  // software reaches only the four arithmetic flags
  wire [3:0] sw_flags = wr_status ? wr_data[3:0] : flag_q[3:0];
  // ALU flag updates win over a write of the status location by the same op
  wire       carry_d  = (alu_exec && upd_carry) ? alu_c : sw_flags[ST_CARRY];
  wire       half_d   = (alu_exec && upd_arith) ? alu_hc : sw_flags[ST_HALF];
  wire       zero_d   = (alu_exec && upd_zero) ? alu_z : sw_flags[ST_ZERO];
  wire       ovf_d    = (alu_exec && upd_arith) ? alu_ov : sw_flags[ST_OVERFLOW];
  // halt sets, watchdog clear clears; set wins
  wire       pwrdn_d  = halt_exec ? 1'b1 :
                        (watchdog_clear_exec ? 1'b0 : flag_q[ST_PWRDN]);
  // timeout sets, clear or halt clears; set wins
  wire       wdog_d   = watchdog_timeout ? 1'b1 :
                        ((watchdog_clear_exec || halt_exec) ? 1'b0 : flag_q[ST_WDOG]);

  // reset stands for power-up, so both special flags start cleared
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag_q <= 6'h00;
    end else begin
      flag_q <= {wdog_d, pwrdn_d, ovf_d, zero_d, half_d, carry_d};
    end
  end

  // ---- return stack
  wire            ret_any = return_exec || return_int_exec;
  wire            stk_full;
  wire [PC_W-1:0] stk_top;
  wire [2:0]      stk_level;
  // acknowledge only with a free level; request keeps pending meanwhile
  wire            ack_ok  = int_request && !stk_full && !int_ack_q && !call_exec && !ret_any;
  // only the program counter goes on the stack
  wire            push    = call_exec || ack_ok;
  wire            pop     = ret_any && !call_exec;

  csd_stack #(
    .DEPTH (STACK_DEPTH),
    .AW    (PC_W)
  ) u_stack (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .push      (push),
    .pop       (pop),
    .push_data (pc_value),
    .top_data  (stk_top),
    .full      (stk_full),
    .level     (stk_level)
  );

  // ---- table address formation
  // current page from program counter
  wire [3:0] tbl_page = table_last_exec ? LAST_PAGE : pc_value[PC_W-1:PC_W-4];
  wire [PC_W-1:0] tbl_addr_d = {tbl_page, tbl_ptr_q};
  wire            tbl_exec   = table_cur_exec || table_last_exec;

  // ---- registered answers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      int_ack_q          <= 1'b0;
      pc_restore_q       <= '0;
      pc_restore_valid_q <= 1'b0;
      table_addr_q       <= '0;
      table_addr_valid_q <= 1'b0;
      rdata_q            <= RST_BYTE;
      skip_q             <= 1'b0;
    end else begin
      int_ack_q          <= ack_ok;
      pc_restore_valid_q <= pop;
      table_addr_valid_q <= tbl_exec;
      skip_q             <= alu_exec && alu_skip;
      // newest entry back to the counter
      if (pop) pc_restore_q <= stk_top;
      if (tbl_exec) table_addr_q <= tbl_addr_d;
      if (mem_read) rdata_q <= loc_data;
    end
  end

  assign int_ack          = int_ack_q;
  assign pc_restore       = pc_restore_q;
  assign pc_restore_valid = pc_restore_valid_q;
  assign table_addr       = table_addr_q;
  assign table_addr_valid = table_addr_valid_q;
  assign mem_rdata        = rdata_q;
  assign skip_next        = skip_q;
  assign accumulator      = acc_q;
  assign status_flags     = flag_q;
  assign stack_level      = stk_level;

endmodule
`default_nettype wire

// file: bench/csd_datapath_assertions.sv
// concurrent checks on the ports of the datapath top module
`timescale 1ns/10ps
`default_nettype none
module csd_datapath_assertions import csd_pkg::*; (
  input wire logic            sys_clk,
  input wire logic            reset,
  input wire logic [PC_W-1:0] pc_value,
  input wire logic            call_exec,
  input wire logic            return_exec,
  input wire logic            return_int_exec,
  input wire logic            int_request,
  input wire logic            int_ack,
  input wire logic            pc_restore_valid,
  input wire logic            table_cur_exec,
  input wire logic            table_last_exec,
  input wire logic [PC_W-1:0] table_addr,
  input wire logic            table_addr_valid,
  input wire logic [7:0]      mem_addr,
  input wire logic            mem_write,
  input wire logic            halt_exec,
  input wire logic            watchdog_clear_exec,
  input wire logic            watchdog_timeout,
  input wire logic [5:0]      status_flags,
  input wire logic [2:0]      stack_level
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_push;
    call_exec && !return_exec && !return_int_exec && stack_level < 3'd6
      |=> stack_level == $past(stack_level) + 3'd1;
  endproperty
  a_push: assert property (p_push) else $error("call did not add a level");
  property p_ack_push;
    int_ack |-> stack_level == $past(stack_level) + 3'd1 ##1 !int_ack;
  endproperty
  a_ack_push: assert property (p_ack_push) else $error("ack without push");
  property p_pop;
    (return_exec || return_int_exec) && !call_exec && stack_level != 3'd0
      |=> pc_restore_valid && stack_level == $past(stack_level) - 3'd1;
  endproperty
  a_pop: assert property (p_pop) else $error("return did not restore");
  property p_full_hold;
    int_request && stack_level == 3'd6 && !return_exec && !return_int_exec |=> !int_ack;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("ack on full stack");
  property p_full_call;
    call_exec && !return_exec && !return_int_exec && stack_level == 3'd6 |=> stack_level == 3'd6;
  endproperty
  a_full_call: assert property (p_full_call) else $error("full call moved level");
  property p_tbl_cur;
    table_cur_exec && !table_last_exec
      |=> table_addr_valid && table_addr[11:8] == $past(pc_value[11:8]);
  endproperty
  a_tbl_cur: assert property (p_tbl_cur) else $error("current page wrong");
  property p_tbl_last;
    table_last_exec && !table_cur_exec |=> table_addr_valid && table_addr[11:8] == 4'hF;
  endproperty
  a_tbl_last: assert property (p_tbl_last) else $error("last page wrong");
  property p_stat_wr;
    mem_write && mem_addr == ADDR_STATUS && !halt_exec && !watchdog_clear_exec
      && !watchdog_timeout |=> $stable(status_flags[5:4]);
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("status write hit flags");
  property p_halt;
    halt_exec && !watchdog_timeout |=> status_flags[5:4] == 2'b01;
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong");
  property p_wd_clear;
    watchdog_clear_exec && !halt_exec && !watchdog_timeout |=> status_flags[5:4] == 2'b00;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("clear flags wrong");
  property p_timeout;
    watchdog_timeout |=> status_flags[5];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");
endmodule
`default_nettype wire

// file: bench/csd_datapath_bench.sv
// directed self-checking bench for the stack, table, memory, ALU and status datapath
`timescale 1ns/10ps
`default_nettype none
module csd_datapath_bench import csd_pkg::*;;
  logic            sys_clk = 1'b0;
  logic            reset = 1'b1;
  logic [PC_W-1:0] pc_value, pc_restore, table_addr;
  logic            call_exec, return_exec, return_int_exec, int_request, int_ack;
  logic            pc_restore_valid, table_cur_exec, table_last_exec, table_addr_valid;
  logic [7:0]      mem_addr, mem_wdata, mem_rdata, alu_imm, accumulator;
  logic            mem_read, mem_write, bit_set_exec, bit_clear_exec, alu_exec;
  logic [2:0]      bit_index, stack_level;
  logic            alu_use_imm, alu_to_mem, skip_next, halt_exec, watchdog_clear_exec;
  logic            watchdog_timeout;
  logic [5:0]      status_flags;
  csd_op_type      alu_op;
  int              failures = 0;
  int              tests_run = 0;
  int              n;
  csd_datapath csd_datapath_inst (.sys_clk, .reset, .pc_value, .call_exec, .return_exec,
    .return_int_exec, .int_request, .int_ack, .pc_restore, .pc_restore_valid,
    .table_cur_exec, .table_last_exec, .table_addr, .table_addr_valid, .mem_addr, .mem_read,
    .mem_write, .mem_wdata, .mem_rdata, .bit_set_exec, .bit_clear_exec, .bit_index,
    .alu_exec, .alu_op, .alu_use_imm, .alu_imm, .alu_to_mem, .skip_next, .halt_exec,
    .watchdog_clear_exec, .watchdog_timeout, .accumulator, .status_flags, .stack_level);
  always #20 sys_clk = ~sys_clk;
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic close_out;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // every access ends with an idle edge so no strobe is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mem_addr = a;
    mem_wdata = d;
    mem_write = 1'b1;
    tick;
    mem_write = 1'b0;
    tick;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    mem_addr = a;
    mem_read = 1'b1;
    tick;
    mem_read = 1'b0;
    chk("rdata", 12'(e), 12'(mem_rdata));
    tick;
  endtask
  task automatic bitop(input logic s, input logic [2:0] i);
    mem_addr = 8'h41;
    bit_index = i;
    bit_set_exec = s;
    bit_clear_exec = !s;
    tick;
    bit_set_exec = 1'b0;
    bit_clear_exec = 1'b0;
    tick;
  endtask
  task automatic alu(input csd_op_type op, input logic [7:0] a, input logic [7:0] imm,
                     input logic [7:0] res, input logic [3:0] f, input logic s);
    wr(ADDR_ACC, a);
    alu_op = op;
    alu_imm = imm;
    alu_use_imm = 1'b1;
    alu_to_mem = 1'b0;
    alu_exec = 1'b1;
    tick;
    alu_exec = 1'b0;
    chk("acc", 12'(res), 12'(accumulator));
    chk("flags", 12'({2'b00, f}), 12'(status_flags));
    chk("skip", 12'(s), 12'(skip_next));
    tick;
  endtask
  task automatic flg(input logic h, input logic c, input logic t, input logic [5:0] e);
    halt_exec = h;
    watchdog_clear_exec = c;
    watchdog_timeout = t;
    tick;
    halt_exec = 1'b0;
    watchdog_clear_exec = 1'b0;
    watchdog_timeout = 1'b0;
    chk("status", 12'(e), 12'(status_flags));
    tick;
  endtask
  task automatic call(input logic [11:0] p);
    pc_value = p;
    call_exec = 1'b1;
    tick;
    call_exec = 1'b0;
    tick;
  endtask
  task automatic ret(input logic intr, input logic [11:0] e);
    return_exec = !intr;
    return_int_exec = intr;
    tick;
    return_exec = 1'b0;
    return_int_exec = 1'b0;
    chk("restore", e, pc_restore);
    chk("restore_valid", 12'h001, 12'(pc_restore_valid));
    tick;
  endtask
  task automatic tbl(input logic last, input logic [11:0] e);
    table_cur_exec = !last;
    table_last_exec = last;
    tick;
    table_cur_exec = 1'b0;
    table_last_exec = 1'b0;
    chk("table_addr", e, table_addr);
    chk("table_valid", 12'h001, 12'(table_addr_valid));
    tick;
  endtask
  initial begin
    {call_exec, return_exec, return_int_exec, int_request, table_cur_exec} = 5'h00;
    {table_last_exec, mem_read, mem_write, bit_set_exec, bit_clear_exec} = 5'h00;
    {alu_exec, alu_use_imm, alu_to_mem, halt_exec, watchdog_clear_exec} = 5'h00;
    {watchdog_timeout, bit_index, pc_value, mem_addr, mem_wdata, alu_imm} = 40'h00;
    alu_op = OP_PASS;
    repeat (3) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    chk("level", 12'h000, 12'(stack_level));
    chk("status", 12'h000, 12'(status_flags));
    rd(8'h20, 8'h00);
    wr(8'h41, 8'hAA);
    rd(8'h41, 8'hAA);
    wr(8'hFF, 8'h5A);
    rd(8'hFF, 8'h5A);
    wr(ADDR_ACC, 8'h3C);
    chk("acc", 12'h03C, 12'(accumulator));
    wr(ADDR_PTR0, 8'h42);
    wr(ADDR_IND0, 8'h55);
    rd(8'h42, 8'h55);
    wr(ADDR_PTR1, 8'h43);
    wr(ADDR_IND1, 8'h66);
    rd(8'h43, 8'h66);
    rd(ADDR_IND0, 8'h55);
    wr(ADDR_PTR0, ADDR_IND1);
    wr(ADDR_IND0, 8'h77);
    rd(ADDR_IND0, 8'h00);
    wr(ADDR_PTR1, ADDR_IND0);
    rd(ADDR_IND1, 8'h00);
    bitop(1'b1, 3'd0);
    bitop(1'b0, 3'd7);
    rd(8'h41, 8'h2B);
    // memory operand, result back to memory
    alu_op = OP_INC;
    alu_use_imm = 1'b0;
    alu_to_mem = 1'b1;
    alu_exec = 1'b1;
    tick;
    alu_exec = 1'b0;
    tick;
    rd(8'h41, 8'h2C);
    alu(OP_ADD, 8'h7F, 8'h01, 8'h80, 4'hA, 1'b0);
    alu(OP_ADD, 8'hFF, 8'h01, 8'h00, 4'h7, 1'b0);
    alu(OP_ADD_CARRY, 8'h10, 8'h01, 8'h12, 4'h0, 1'b0);
    alu(OP_SUB, 8'h05, 8'h03, 8'h02, 4'h3, 1'b0);
    alu(OP_SUB, 8'h03, 8'h05, 8'hFE, 4'h0, 1'b0);
    alu(OP_SUB_BORROW, 8'h10, 8'h01, 8'h0E, 4'h1, 1'b0);
    alu(OP_AND, 8'hF0, 8'h0F, 8'h00, 4'h5, 1'b0);
    alu(OP_OR, 8'hF0, 8'h0F, 8'hFF, 4'h1, 1'b0);
    alu(OP_XOR, 8'hFF, 8'hFF, 8'h00, 4'h5, 1'b0);
    alu(OP_COMPLEMENT, 8'h00, 8'h0F, 8'hF0, 4'h1, 1'b0);
    alu(OP_ROT_LEFT_C, 8'h00, 8'h80, 8'h01, 4'h1, 1'b0);
    alu(OP_ROT_RIGHT_C, 8'h00, 8'h02, 8'h81, 4'h0, 1'b0);
    alu(OP_ROT_LEFT, 8'h00, 8'h81, 8'h03, 4'h0, 1'b0);
    alu(OP_ROT_RIGHT, 8'h00, 8'h01, 8'h80, 4'h0, 1'b0);
    alu(OP_INC, 8'h00, 8'hFF, 8'h00, 4'h4, 1'b0);
    alu(OP_DEC, 8'h00, 8'h01, 8'h00, 4'h4, 1'b0);
    alu(OP_DEC_ADJUST, 8'h0A, 8'h00, 8'h10, 4'h4, 1'b0);
    alu(OP_SKIP_ZERO, 8'h33, 8'h00, 8'h33, 4'h4, 1'b1);
    alu(OP_SKIP_NONZERO, 8'h33, 8'h00, 8'h33, 4'h4, 1'b0);
    alu(OP_INC_SKIP_ZERO, 8'h33, 8'hFF, 8'h00, 4'h4, 1'b1);
    alu(OP_DEC_SKIP_ZERO, 8'h33, 8'h02, 8'h01, 4'h4, 1'b0);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h0F);
    flg(1'b1, 1'b0, 1'b0, 6'h1F);
    flg(1'b0, 1'b0, 1'b1, 6'h3F);
    flg(1'b1, 1'b0, 1'b0, 6'h1F);
    flg(1'b0, 1'b1, 1'b0, 6'h0F);
    flg(1'b0, 1'b0, 1'b1, 6'h2F);
    flg(1'b0, 1'b1, 1'b0, 6'h0F);
    for (int i = 1; i <= 7; i++) call(12'h100 + 12'(i));
    chk("level", 12'h006, 12'(stack_level));
    chk("status", 12'h00F, 12'(status_flags));
    pc_value = 12'h200;
    int_request = 1'b1;
    repeat (4) begin
      tick;
      chk("int_ack", 12'h000, 12'(int_ack));
    end
    ret(1'b0, 12'h107);
    n = 0;
    while (int_ack !== 1'b1) begin
      if (n == 8) begin
        failures++;
        close_out;
      end
      tick;
      n++;
    end
    int_request = 1'b0;
    chk("level", 12'h006, 12'(stack_level));
    tick;
    ret(1'b1, 12'h200);
    for (int i = 6; i >= 2; i--) ret(1'b0, 12'h100 + 12'(i));
    chk("level", 12'h000, 12'(stack_level));
    wr(ADDR_TBL_PTR, 8'h5C);
    pc_value = 12'hA34;
    tbl(1'b0, 12'hA5C);
    tbl(1'b1, 12'hF5C);
    close_out;
  end
endmodule
bind csd_datapath csd_datapath_assertions csd_datapath_assertions_inst (.sys_clk, .reset,
  .pc_value, .call_exec, .return_exec, .return_int_exec, .int_request, .int_ack,
  .pc_restore_valid, .table_cur_exec, .table_last_exec, .table_addr, .table_addr_valid,
  .mem_addr, .mem_write, .halt_exec, .watchdog_clear_exec, .watchdog_timeout,
  .status_flags, .stack_level);
`default_nettype wire
